// ---- common/isf_pkg.sv ----
// Package: constants and the carrier type for the input sampling filter
package isf_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS   = 4000;
    localparam int unsigned SAMPLE_TIME_US  = 500;
    localparam int unsigned REFRESH_TIME_US = 2000;
    localparam int unsigned SAMPLE_CYCLES   = (SAMPLE_TIME_US * 1000) / CLK_PERIOD_PS;
    localparam int unsigned SAMPLES_PER_REF = REFRESH_TIME_US / SAMPLE_TIME_US;

    // ------------------------------------------------------------
    // Filter setting and input count
    // ------------------------------------------------------------
    localparam int unsigned FILT_MAX_CODE   = 40;
    localparam logic [5:0]  FILT_CODE_RESET = 6'h00;
    localparam int unsigned NUM_INPUTS      = 16;

    // ------------------------------------------------------------
    // Carrier for one refresh write into the interface RAM
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  wr;
        logic [NUM_INPUTS-1:0] data;
    } isf_ram_wr_t;

endpackage : isf_pkg

// ---- design/isf_filter.sv ----
// Module: standard input sampler, agreement filter and refresh writer
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Every standard input is sampled once per 0.5 ms tick regardless of the host; the code ticks every 125 clocks of 4 ns, 0.5 us.
// - Every 2 ms the status of all standard inputs is written to the interface RAM; the code writes every 4 ticks, 2 us.
// - With filtering on, the refresh writes the filtered result rather than the raw sample.
// - The filter window is programmable from 0.5 ms to 20 ms in 0.5 ms steps; the code gives 0.5 us to 20 us in 0.5 us steps.
// - The filter setting is a code 0 to 40, default 0, one unit per 0.5 ms; others are invalid. The code's unit is one 0.5 us tick.
// - Each sample is kept in a history, so that with filtering on the refresh can judge the whole window.
// - If all samples in the window agree, that level is reported.
// - If samples in the window disagree, the previous reported value is kept.
// - Until enough samples cover the window, the filtered status reads OFF.
// - Inputs assigned to special functions are not reported as standard inputs.
// - A setting of zero disables filtering and the raw sample is written.
module isf_filter
    import isf_pkg::*;
#(
    parameter int unsigned N_IN       = NUM_INPUTS,
    parameter int unsigned MAX_CODE   = FILT_MAX_CODE,
    parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES
)
(
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic [N_IN-1:0]   din,
    input  wire logic [N_IN-1:0]   special_mask,
    input  wire logic [5:0]        filt_code,
    output var  logic              ram_wr,
    output var  logic [N_IN-1:0]   ram_data,
    output var  logic              code_err
);
    localparam int unsigned HW = MAX_CODE;
    localparam int unsigned KW = $clog2(MAX_CODE + 1);
    localparam int unsigned GW = $clog2(SAMPLE_CYC + 1);

    initial
    begin
        if (N_IN < 1 || N_IN > NUM_INPUTS || MAX_CODE < 2 || MAX_CODE > FILT_MAX_CODE)
            $error("isf_filter: bad parameters");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [HW-1:0] win_mask(input logic [5:0] code);
        logic [HW-1:0] m;
        m = '0;
        for (int i = 0; i < HW; i++)
            if (i < int'(code))
                m[i] = 1'b1;
        return m;
    endfunction : win_mask

    function automatic logic code_ok(input logic [5:0] code);
        return code <= 6'(MAX_CODE);
    endfunction : code_ok

    // ------------------------------------------------------------
    // Ticks
    // ------------------------------------------------------------
    logic sample_tick;
    logic refresh_tick;

    isf_tick_gen #(
        .SAMPLE_CYC (SAMPLE_CYC),
        .PER_REF    (SAMPLES_PER_REF)
    ) u_tick (
        .clk_sys      (clk_sys),
        .nrst         (nrst),
        .sample_tick  (sample_tick),
        .refresh_tick (refresh_tick)
    );

    // ------------------------------------------------------------
    // Setting capture
    // ------------------------------------------------------------
    logic [5:0] code_reg;
    logic [5:0] code_next;

    always_comb
    begin
        code_next = code_ok(filt_code) ? filt_code : code_reg;
    end

    // Window restarts when the setting changes
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            code_reg <= FILT_CODE_RESET;
        else
            code_reg <= code_next;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            code_err <= 1'b0;
        else
            code_err <= !code_ok(filt_code);
    end

    // ------------------------------------------------------------
    // Sampling and history
    // ------------------------------------------------------------
    logic [N_IN-1:0] raw_reg;
    logic [HW-1:0]   hist_reg [N_IN];
    logic [KW-1:0]   cnt_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            raw_reg <= '0;
        else if (sample_tick)
            raw_reg <= din;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < N_IN; i++)
                hist_reg[i] <= '0;
        end
        else if (sample_tick)
        begin
            for (int i = 0; i < N_IN; i++)
                hist_reg[i] <= {hist_reg[i][HW-2:0], din[i]};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst || code_next != code_reg)
            cnt_reg <= '0;
        else if (sample_tick && cnt_reg < KW'(MAX_CODE))
            cnt_reg <= cnt_reg + 1'b1;
    end

    // ------------------------------------------------------------
    // Filter decision
    // ------------------------------------------------------------
    logic [N_IN-1:0] filt_reg;
    logic [N_IN-1:0] filt_next;
    logic [HW-1:0]   wm;
    logic            full;

    always_comb
    begin
        wm        = win_mask(code_reg);
        full      = cnt_reg >= KW'(code_reg);
        filt_next = filt_reg;
        for (int i = 0; i < N_IN; i++)
        begin
            if (code_reg == 6'h00)
                filt_next[i] = raw_reg[i];
            else if (!full)
                filt_next[i] = 1'b0;
            else if ((hist_reg[i] & wm) == wm)
                filt_next[i] = 1'b1;
            else if ((hist_reg[i] & wm) == '0)
                filt_next[i] = 1'b0;
            else
                filt_next[i] = filt_reg[i];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            filt_reg <= '0;
        else if (refresh_tick)
            filt_reg <= filt_next;
    end

    // ------------------------------------------------------------
    // Refresh write
    // ------------------------------------------------------------
    isf_ram_wr_t wr_next;

    always_comb
    begin
        wr_next.wr   = refresh_tick;
        wr_next.data = '0;
        if (code_reg == 6'h00)
            wr_next.data[N_IN-1:0] = raw_reg & ~special_mask;
        else
            wr_next.data[N_IN-1:0] = filt_next & ~special_mask;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            ram_wr <= 1'b0;
        else
            ram_wr <= wr_next.wr;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            ram_data <= '0;
        else if (refresh_tick)
            ram_data <= wr_next.data[N_IN-1:0];
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [GW-1:0] gap_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst || sample_tick)
            gap_reg <= '0;
        else
            gap_reg <= gap_reg + 1'b1;
    end

    a_write_spacing: assert property (@(posedge clk_sys) disable iff (!nrst)
        ram_wr |=> !ram_wr[*8])
        else $error("refresh writes too close");

    a_special_masked: assert property (@(posedge clk_sys) disable iff (!nrst)
        ram_wr |-> (ram_data & $past(special_mask)) == '0)
        else $error("special input reported");

    a_raw_unfiltered: assert property (@(posedge clk_sys) disable iff (!nrst)
        refresh_tick && code_reg == 6'h00 |=> ram_data == ($past(raw_reg) & ~$past(special_mask)))
        else $error("raw status not written");

    a_short_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        refresh_tick && code_reg != 6'h00 && cnt_reg < KW'(code_reg) |=> ram_data == '0)
        else $error("status not off before window filled");

    a_code_range: assert property (@(posedge clk_sys) disable iff (!nrst)
        !code_ok(filt_code) |=> $stable(code_reg))
        else $error("invalid filter code taken");

    a_agree_report: assert property (@(posedge clk_sys) disable iff (!nrst)
        refresh_tick && code_reg != 6'h00 && full && (hist_reg[0] & wm) == wm && !special_mask[0]
        |=> ram_data[0])
        else $error("agreed high not reported");

    a_hold_value: assert property (@(posedge clk_sys) disable iff (!nrst)
        refresh_tick && code_reg != 6'h00 && full && (hist_reg[0] & wm) != wm && (hist_reg[0] & wm) != '0
        |=> filt_reg[0] == $past(filt_reg[0]))
        else $error("disagreeing input changed");

    a_sample_rate: assert property (@(posedge clk_sys) disable iff (!nrst)
        sample_tick |-> gap_reg >= GW'(SAMPLE_CYC - 1))
        else $error("samples too close");

    a_sample_due: assert property (@(posedge clk_sys) disable iff (!nrst)
        gap_reg >= GW'(SAMPLE_CYC) |-> sample_tick)
        else $error("sample tick missing");

    a_filtered_out: assert property (@(posedge clk_sys) disable iff (!nrst)
        refresh_tick && code_reg != 6'h00 |=> ram_data == ($past(filt_next) & ~$past(special_mask)))
        else $error("filtered result not written");
endmodule : isf_filter
`default_nettype wire

// ---- design/isf_tick_gen.sv ----
// Module: tick generator for sample and refresh events
`timescale 1ns/100ps
`default_nettype none
module isf_tick_gen
    import isf_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES,
    parameter int unsigned PER_REF    = SAMPLES_PER_REF
)
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    output var  logic sample_tick,
    output var  logic refresh_tick
);
    localparam int unsigned CW = $clog2(SAMPLE_CYC);
    localparam int unsigned RW = (PER_REF > 1) ? $clog2(PER_REF) : 1;

    initial
    begin
        if (SAMPLE_CYC < 2 || PER_REF < 1)
            $error("isf_tick_gen: bad tick parameters");
    end

    logic [CW-1:0] cyc_reg;
    logic [RW-1:0] ref_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cyc_reg     <= '0;
            sample_tick <= 1'b0;
        end
        else
        begin
            sample_tick <= (cyc_reg == CW'(SAMPLE_CYC - 1));
            cyc_reg     <= (cyc_reg == CW'(SAMPLE_CYC - 1)) ? '0 : cyc_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            ref_reg      <= '0;
            refresh_tick <= 1'b0;
        end
        else
        begin
            refresh_tick <= 1'b0;
            if (cyc_reg == CW'(SAMPLE_CYC - 1))
            begin
                refresh_tick <= (ref_reg == RW'(PER_REF - 1));
                ref_reg      <= (ref_reg == RW'(PER_REF - 1)) ? '0 : ref_reg + 1'b1;
            end
        end
    end
endmodule : isf_tick_gen
`default_nettype wire

// ---- tb/input_sampling_debounce_filter_tb.sv ----
// Testbench: random and corner checks of the input sampling filter
`timescale 1ns/100ps
`default_nettype none
module input_sampling_debounce_filter_tb;
    import isf_pkg::*;
    localparam int unsigned N  = NUM_INPUTS;
    localparam int unsigned SC = 4;
    localparam int unsigned RP = SAMPLES_PER_REF * SC;

    logic         clk_sys      = 1'b0;
    logic         nrst         = 1'b0;
    logic [N-1:0] din          = 16'h0000;
    logic [N-1:0] special_mask = 16'h0000;
    logic [5:0]   filt_code    = 6'h00;
    logic         ram_wr;
    logic [N-1:0] ram_data;
    logic         code_err;
    logic [N-1:0] host_view;
    logic [N-1:0] lfsr         = 16'h0044;
    logic [N-1:0] held;
    logic [N-1:0] pat;
    int           err_count    = 0;
    int           checks_done  = 0;
    int           k;
    int           c;
    int           n;

    always #2 clk_sys = ~clk_sys;

    isf_filter #(.SAMPLE_CYC(SC)) dut (
        .clk_sys      (clk_sys),
        .nrst         (nrst),
        .din          (din),
        .special_mask (special_mask),
        .filt_code    (filt_code),
        .ram_wr       (ram_wr),
        .ram_data     (ram_data),
        .code_err     (code_err)
    );

    isf_host_model host (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .wr_in     (isf_ram_wr_t'({ram_wr, ram_data})),
        .host_view (host_view)
    );

    function automatic logic [N-1:0] next_rand();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : next_rand

    function automatic logic [N-1:0] expect_fn(input logic [N-1:0] x, input logic [N-1:0] m);
        return x & ~m;
    endfunction : expect_fn

    task automatic check(input logic [N-1:0] seen, input logic [N-1:0] want);
        checks_done++;
        if (seen !== want)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic step(input int cyc);
        repeat (cyc)
        begin
            @(posedge clk_sys);
            #1;
        end
    endtask : step

    // Waits for the next write strobe and returns the cycles spent
    task automatic wait_wr(output int cyc);
        step(1);
        for (cyc = 1; cyc < 3 * RP && ram_wr !== 1'b1; cyc++)
            step(1);
        check(N'(ram_wr), N'(1'b1));
    endtask : wait_wr

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        finish_test();
    end

    initial
    begin
        step(15);
        check(ram_data | N'(ram_wr), 16'h0000);
        step(1);
        nrst = 1'b1;
        // Raw mode: period, pulse width and masking
        for (k = 0; k < 6; k++)
        begin
            held = next_rand();
            din = held;
            special_mask = next_rand();
            wait_wr(n);
            wait_wr(n);
            check(N'(n), N'(RP));
            check(ram_data, expect_fn(held, special_mask));
            step(1);
            check(N'(ram_wr), 16'h0000);
        end
        // Every valid window length
        for (c = 1; c <= int'(FILT_MAX_CODE); c++)
        begin
            held = next_rand();
            din = held;
            special_mask = next_rand();
            filt_code = 6'(c);
            wait_wr(n);
            if (c >= int'(SAMPLES_PER_REF))
                check(ram_data, 16'h0000);
            repeat (c / 4 + 2) wait_wr(n);
            check(ram_data, expect_fn(held, special_mask));
        end
        // Short window, then samples that disagree every tick
        filt_code = 6'h02;
        repeat (3) wait_wr(n);
        check(ram_data, expect_fn(held, special_mask));
        pat = next_rand();
        for (k = 0; k < 25; k++)
        begin
            din = din ^ pat;
            step(SC);
        end
        check(ram_data, expect_fn(held, special_mask));
        repeat (2) wait_wr(n);
        check(ram_data, expect_fn(held ^ pat, special_mask));
        // Out-of-range codes are refused and the old window stays
        for (c = 41; c < 64; c += 11)
        begin
            filt_code = 6'(c);
            step(3);
            check(N'(code_err), N'(1'b1));
        end
        din = held;
        repeat (2) wait_wr(n);
        check(ram_data, expect_fn(held, special_mask));
        filt_code = 6'h28;
        step(3);
        check(N'(code_err), 16'h0000);
        filt_code = 6'h00;
        held = next_rand();
        din = held;
        repeat (2) wait_wr(n);
        check(ram_data, expect_fn(held, special_mask));
        step(40);
        check(host_view, expect_fn(held, special_mask));
        // Mid-run reset with an invalid setting: the code falls back to 0
        nrst = 1'b0;
        filt_code = 6'h3F;
        step(2);
        check(ram_data | N'(ram_wr) | N'(code_err), 16'h0000);
        nrst = 1'b1;
        wait_wr(n);
        check(N'(n), N'(RP + 1));
        check(ram_data, expect_fn(held, special_mask));
        check(N'(code_err), N'(1'b1));
        finish_test();
    end
endmodule : input_sampling_debounce_filter_tb
`default_nettype wire

// ---- tb/isf_host_model.sv ----
// Host model: interface RAM written by refresh, read once per program scan
`timescale 1ns/100ps
`default_nettype none
module isf_host_model
    import isf_pkg::*;
#(
    parameter int unsigned SCAN_CYC = 37
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire isf_ram_wr_t           wr_in,
    output var  logic [NUM_INPUTS-1:0] host_view
);
    logic [NUM_INPUTS-1:0] ram_reg;
    logic [7:0]            scan_cnt_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            ram_reg <= '0;
        else if (wr_in.wr)
            ram_reg <= wr_in.data;
    end

    // Scan counter; the status is fetched once per scan
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            scan_cnt_reg <= 8'h00;
            host_view    <= '0;
        end
        else if (scan_cnt_reg == 8'(SCAN_CYC - 1))
        begin
            scan_cnt_reg <= 8'h00;
            host_view    <= ram_reg;
        end
        else
            scan_cnt_reg <= scan_cnt_reg + 8'h01;
    end
endmodule : isf_host_model
`default_nettype wire
